//--- logic/pss_speed_select.sv
`timescale 1ns/10ps
module pss_speed_select #(
	parameter int W = pss_pkg::FREQ_W,
	parameter int PINS = pss_pkg::PIN_N
) (
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	// Contact pins and run commands, asynchronous
	input wire logic [PINS-1:0] input_pins,
	input wire logic forward_run_command,
	input wire logic reverse_run_command,
	input wire logic second_function_select,
	// Pin function mapping, four bits per pin
	input wire logic [4*PINS-1:0] input_pin_function_params,
	// Mode parameters
	input wire logic [3:0] operation_mode_param,
	input wire logic [1:0] remote_function_select_param,
	input wire logic ramp_time_unit_param,
	input wire logic [1:0] param_write_select,
	// Preset table write port
	input wire logic preset_wr_en,
	input wire logic [3:0] preset_wr_index,
	input wire logic [W-1:0] preset_wr_value,
	// Inching and ramp parameter writes
	input wire logic inching_freq_wr_en,
	input wire logic inching_ramp_wr_en,
	input wire logic ramp_ref_wr_en,
	input wire logic [W-1:0] param_wr_value,
	// Analog derived commands
	input wire logic analog2_valid,
	input wire logic [W-1:0] analog2_freq,
	input wire logic [W-1:0] analog1_freq,
	// Results
	output logic [W-1:0] freq_command,
	output pss_pkg::pss_src_e command_source,
	output logic run_enable,
	output logic [W-1:0] ramp_time,
	output logic ramp_time_fine,
	output logic [W-1:0] ramp_reference_frequency,
	output logic use_second_ramp,
	output logic remote_enable
);
	// Two-stage synchronisers
	logic [PINS+2:0] sync_a;
	logic [PINS+2:0] sync_b;
	// Parameter registers
	logic [W-1:0] inching_frequency_param;
	logic [W-1:0] inching_ramp_time_param;
	logic [W-1:0] ramp_reference_frequency_param;
	// Decoded functions
	pss_pin_if pins_if ();
	// Preset table read data
	logic [W-1:0] table_value;

	// Synchronise asynchronous contacts
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			sync_a <= '0;
			sync_b <= '0;
		end
		else if (clk_en)
		begin
			sync_a <= {second_function_select, reverse_run_command,
				forward_run_command, input_pins};
			sync_b <= sync_a;
		end
	end

	wire [PINS-1:0] pin_level = sync_b[PINS-1:0];
	wire run_cmd = sync_b[PINS] | sync_b[PINS+1];
	wire second_fn = sync_b[PINS+2];

	// Function routing by mapping codes
	pss_pin_map #(.PINS(PINS)) u_map (
		.pin_level(pin_level),
		.pin_function(input_pin_function_params),
		.fn(pins_if.source)
	);

	wire s_low = pins_if.speed_low_input;
	wire s_mid = pins_if.speed_mid_input;
	wire s_high = pins_if.speed_high_input;
	wire s_ext = pins_if.extra_speed_bit;
	wire inching = pins_if.inching_select;

	// Fixed combination lookup {extra,high,mid,low} to table index
	function automatic logic [3:0] combo_index(input logic [3:0] c);
		logic [3:0] idx;
		idx = 4'h0;
		case (c)
			4'h1: idx = pss_pkg::IDX_LOW;
			4'h2: idx = pss_pkg::IDX_MID;
			4'h4: idx = pss_pkg::IDX_HIGH;
			4'h3: idx = pss_pkg::IDX_LOW;
			4'h6: idx = pss_pkg::IDX_MID;
			4'h5: idx = pss_pkg::IDX_LOW;
			4'h7: idx = pss_pkg::IDX_LOW;
			4'h8: idx = 4'h8;
			4'h9: idx = 4'h9;
			4'hA: idx = 4'hA;
			4'hB: idx = 4'hB;
			4'hC: idx = 4'hC;
			4'hD: idx = 4'hD;
			4'hE: idx = 4'hE;
			4'hF: idx = 4'hF;
			default: idx = 4'h0;
		endcase
		return idx;
	endfunction

	// Speeds 4..7 use combos of two or all three inputs without extra bit
	function automatic logic [3:0] full_index(input logic [3:0] c);
		logic [3:0] idx;
		idx = combo_index(c);
		// Speed 4..7 combos replace the pairwise priority
		case (c)
			4'h3: idx = 4'h5;
			4'h5: idx = 4'h6;
			4'h6: idx = 4'h4;
			4'h7: idx = 4'h7;
			default: idx = idx;
		endcase
		return idx;
	endfunction

	wire [3:0] combo = {s_ext, s_high, s_mid, s_low};
	wire [3:0] ext_index = full_index(combo);
	wire [3:0] pri_index = combo_index(combo);

	// Speed 4..15 used only when programmed; else 4..7 fall back to priority, 8 gives zero, 9..15 give analog
	pss_preset_table #(.W(W)) u_table (
		.mclk(mclk),
		.reset(reset),
		.clk_en(clk_en),
		.wr_en(preset_wr_en),
		.wr_index(preset_wr_index),
		.wr_value(preset_wr_value),
		.rd_index(ext_index),
		.rd_value(table_value)
	);

	wire ext_unused = table_value == pss_pkg::NOT_SELECTED;
	wire is_extended = ext_index > pss_pkg::IDX_LOW;
	wire speed8_zero = (combo == 4'h8) && ext_unused;
	wire fallback = is_extended && ext_unused && !speed8_zero
		&& (pri_index != 4'h0) && (pri_index <= pss_pkg::IDX_LOW);
	wire [3:0] fb_index = pri_index;
	// Shadow copies of low and mid presets, read by the fallback path
	logic [W-1:0] preset_low_shadow;
	logic [W-1:0] preset_mid_shadow;
	// Second look-up only for the pairwise fallback
	logic [W-1:0] fb_value;
	always_comb
	begin
		case (fb_index)
			pss_pkg::IDX_LOW: fb_value = preset_low_shadow;
			pss_pkg::IDX_MID: fb_value = preset_mid_shadow;
			default: fb_value = preset_low_shadow;
		endcase
	end

	// Shadow copies follow the table writes for index low and mid
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			preset_low_shadow <= pss_pkg::LOW_RESET;
			preset_mid_shadow <= pss_pkg::MID_RESET;
		end
		else if (clk_en && preset_wr_en &&
			preset_wr_value <= pss_pkg::FREQ_MAX)
		begin
			if (preset_wr_index == pss_pkg::IDX_LOW)
				preset_low_shadow <= preset_wr_value;
			if (preset_wr_index == pss_pkg::IDX_MID)
				preset_mid_shadow <= preset_wr_value;
		end
	end

	// Preset allowed by mode and remote setting
	wire mode_ext = (operation_mode_param == pss_pkg::MODE_EXTERNAL) ||
		(operation_mode_param == pss_pkg::MODE_COMBINED);
	wire remote_off = remote_function_select_param == 2'h0;
	wire preset_active = mode_ext && remote_off && (combo != 4'h0)
		&& !(is_extended && ext_unused && !speed8_zero && !fallback);
	wire [W-1:0] preset_value = speed8_zero ? pss_pkg::ZERO_FREQ :
		(fallback ? fb_value : table_value);

	// Inching valid in any mode
	wire inch_active = inching;

	// Parameter writes, range checked
	wire ramp_limit_ok = param_wr_value <= (ramp_time_unit_param ?
		pss_pkg::RAMP_MAX_FINE : pss_pkg::RAMP_MAX_COARSE);
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			inching_frequency_param <= pss_pkg::INCH_FREQ_RESET;
			inching_ramp_time_param <= pss_pkg::INCH_RAMP_RESET;
			ramp_reference_frequency_param <= pss_pkg::RAMP_REF_RESET;
		end
		else if (clk_en)
		begin
			if (inching_freq_wr_en && param_wr_value <= pss_pkg::FREQ_MAX)
				inching_frequency_param <= param_wr_value;
			if (inching_ramp_wr_en && ramp_limit_ok)
				inching_ramp_time_param <= param_wr_value;
			if (ramp_ref_wr_en && param_wr_value <= pss_pkg::FREQ_MAX)
				ramp_reference_frequency_param <= param_wr_value;
		end
	end

	// Priority resolution of the command
	logic [W-1:0] next_freq;
	pss_pkg::pss_src_e next_src;
	always_comb
	begin
		if (inch_active)
		begin
			next_freq = inching_frequency_param;
			next_src = pss_pkg::PSS_SRC_INCH;
		end
		else if (preset_active)
		begin
			next_freq = preset_value;
			next_src = pss_pkg::PSS_SRC_PRESET;
		end
		else
		begin
			next_freq = analog2_valid ? analog2_freq :
				analog1_freq;
			next_src = pss_pkg::PSS_SRC_ANALOG;
		end
	end

	// Registered outputs
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			freq_command <= pss_pkg::ZERO_FREQ;
			command_source <= pss_pkg::PSS_SRC_ANALOG;
			run_enable <= 1'b0;
			ramp_time <= pss_pkg::INCH_RAMP_RESET;
			ramp_time_fine <= 1'b0;
			ramp_reference_frequency <= pss_pkg::RAMP_REF_RESET;
			use_second_ramp <= 1'b0;
			remote_enable <= 1'b0;
		end
		else if (clk_en)
		begin
			freq_command <= next_freq;
			command_source <= next_src;
			run_enable <= run_cmd;
			ramp_time <= inching_ramp_time_param;
			ramp_time_fine <= ramp_time_unit_param;
			ramp_reference_frequency <= ramp_reference_frequency_param;
			use_second_ramp <= second_fn && !inch_active;
			remote_enable <= !remote_off && !inch_active;
		end
	end

	// Write select does not gate preset writes
	wire unused_ws = ^param_write_select;

	// Guards on the registered outputs, one cycle after the cause
	AST_INCH_FIRST: assert property (@(posedge mclk)
		disable iff (reset) clk_en && inch_active
		|=> freq_command == $past(inching_frequency_param))
		else $error("inching not first");
	AST_NO_PRESET_REMOTE: assert property (@(posedge mclk)
		disable iff (reset) clk_en && !remote_off && !inch_active
		|=> command_source == pss_pkg::PSS_SRC_ANALOG)
		else $error("preset used in remote mode");
	AST_MODE: assert property (@(posedge mclk)
		disable iff (reset) clk_en && !mode_ext && !inch_active
		|=> command_source != pss_pkg::PSS_SRC_PRESET)
		else $error("preset outside modes 3 and 4");
	AST_RUN: assert property (@(posedge mclk)
		disable iff (reset) clk_en && !run_cmd |=> !run_enable)
		else $error("run without command");
	AST_SPEED8: assert property (@(posedge mclk)
		disable iff (reset)
		clk_en && speed8_zero && mode_ext && remote_off && !inch_active
		|=> freq_command == pss_pkg::ZERO_FREQ)
		else $error("speed 8 unused not zero");
	AST_SECOND: assert property (@(posedge mclk)
		disable iff (reset) clk_en && inch_active
		|=> !use_second_ramp && !remote_enable)
		else $error("second ramp during inching");
	AST_ANALOG: assert property (@(posedge mclk)
		disable iff (reset)
		clk_en && !inch_active && !preset_active && !analog2_valid
		|=> freq_command == $past(analog1_freq))
		else $error("analog not passed");
	AST_MID_WINS: assert property (@(posedge mclk)
		disable iff (reset)
		clk_en && combo == 4'h2 && mode_ext && remote_off && !inch_active
		|=> freq_command == $past(table_value))
		else $error("mid preset not used");
	COV_INCH: cover property (@(posedge mclk) inch_active && run_cmd);
	COV_PRESET: cover property (@(posedge mclk) preset_active);
	COV_S8: cover property (@(posedge mclk) speed8_zero);
endmodule // pss_speed_select

//--- logic/pss_pkg.sv
package pss_pkg;
	// Frequency values in 0.01 Hz units
	localparam int FREQ_W = 16;
	// Marker for an unused preset
	localparam logic [15:0] NOT_SELECTED = 16'h270F;
	// Top of the programmable range, 400 Hz
	localparam logic [15:0] FREQ_MAX = 16'h9C40;
	// Reset values: 60 Hz, 30 Hz, 10 Hz, 5 Hz
	localparam logic [15:0] HIGH_RESET = 16'h1770;
	localparam logic [15:0] MID_RESET = 16'h0BB8;
	localparam logic [15:0] LOW_RESET = 16'h03E8;
	localparam logic [15:0] INCH_FREQ_RESET = 16'h01F4;
	localparam logic [15:0] ZERO_FREQ = 16'h0000;
	// Inching ramp time after reset, 0.5 s in 0.1 s steps
	localparam logic [15:0] INCH_RAMP_RESET = 16'h0005;
	// Ramp time limits: 3600 s in 0.1 s, 360 s in 0.01 s
	localparam logic [15:0] RAMP_MAX_COARSE = 16'h8CA0;
	localparam logic [15:0] RAMP_MAX_FINE = 16'h8CA0;
	// Ramp reference frequency after reset, 60 Hz
	localparam logic [15:0] RAMP_REF_RESET = 16'h1770;
	// Operation mode codes
	localparam logic [3:0] MODE_EXTERNAL = 4'h3;
	localparam logic [3:0] MODE_COMBINED = 4'h4;
	// Input pin function codes
	localparam logic [3:0] FN_LOW = 4'h0;
	localparam logic [3:0] FN_MID = 4'h1;
	localparam logic [3:0] FN_HIGH = 4'h2;
	localparam logic [3:0] FN_INCH = 4'h5;
	localparam logic [3:0] FN_EXTRA = 4'h8;
	localparam logic [3:0] FN_NONE = 4'hF;
	// Number of input pins, and parameter indices of the preset table
	localparam int PIN_N = 7;
	localparam logic [3:0] IDX_HIGH = 4'h1;
	localparam logic [3:0] IDX_MID = 4'h2;
	localparam logic [3:0] IDX_LOW = 4'h3;
	localparam logic [3:0] IDX_SPEED8 = 4'h8;
	// Command source
	typedef enum logic [1:0] {PSS_SRC_ANALOG, PSS_SRC_PRESET,
		PSS_SRC_INCH} pss_src_e;
endpackage

//--- logic/pss_pin_if.sv
`timescale 1ns/10ps
// Decoded contact functions passed from the pin mapper
interface pss_pin_if;
	logic speed_low_input;
	logic speed_mid_input;
	logic speed_high_input;
	logic extra_speed_bit;
	logic inching_select;
	modport source (output speed_low_input, speed_mid_input,
		speed_high_input, extra_speed_bit, inching_select);
	modport sink (input speed_low_input, speed_mid_input,
		speed_high_input, extra_speed_bit, inching_select);
endinterface

//--- logic/pss_pin_map.sv
`timescale 1ns/10ps
// Routes synchronised pins to functions by their function codes
module pss_pin_map #(
	parameter int PINS = pss_pkg::PIN_N
) (
	// Synchronised pin levels
	input wire logic [PINS-1:0] pin_level,
	// Function code of each pin, four bits per pin
	input wire logic [4*PINS-1:0] pin_function,
	// Decoded functions
	pss_pin_if.source fn
);
	// OR of all pins carrying a given code
	function automatic logic pick(input logic [PINS-1:0] lv,
		input logic [4*PINS-1:0] code, input logic [3:0] want);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < PINS; i++)
			hit = hit | (lv[i] & (code[4*i +: 4] == want));
		return hit;
	endfunction

	assign fn.speed_low_input = pick(pin_level, pin_function,
		pss_pkg::FN_LOW);
	assign fn.speed_mid_input = pick(pin_level, pin_function,
		pss_pkg::FN_MID);
	assign fn.speed_high_input = pick(pin_level, pin_function,
		pss_pkg::FN_HIGH);
	assign fn.extra_speed_bit = pick(pin_level, pin_function,
		pss_pkg::FN_EXTRA);
	assign fn.inching_select = pick(pin_level, pin_function,
		pss_pkg::FN_INCH);
endmodule // pss_pin_map

//--- logic/pss_preset_table.sv
`timescale 1ns/10ps
// Fifteen preset frequencies with write port and one read port
module pss_preset_table #(
	parameter int W = pss_pkg::FREQ_W
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	// Write port, accepted at any time
	input wire logic wr_en,
	input wire logic [3:0] wr_index,
	input wire logic [W-1:0] wr_value,
	// Read port
	input wire logic [3:0] rd_index,
	output logic [W-1:0] rd_value
);
	// Index 0 unused; 1..3 high/mid/low, 4..15 speeds
	logic [W-1:0] freq [15:0];
	// Range check: 0..400 Hz, or unused marker above speed 3
	wire value_ok = (wr_value <= pss_pkg::FREQ_MAX) ||
		((wr_index > pss_pkg::IDX_LOW) &&
		(wr_value == pss_pkg::NOT_SELECTED));
	wire do_write = wr_en && (wr_index != 4'h0) && value_ok;

	// Table storage; writes work while running
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < 16; i++)
				freq[i] <= pss_pkg::NOT_SELECTED;
			freq[1] <= pss_pkg::HIGH_RESET;
			freq[2] <= pss_pkg::MID_RESET;
			freq[3] <= pss_pkg::LOW_RESET;
		end
		else if (clk_en && do_write)
			freq[wr_index] <= wr_value;
	end

	assign rd_value = freq[rd_index];
endmodule // pss_preset_table

//--- dv/pss_contact_model.sv
`timescale 1ns/10ps
// Outside contacts and run switches facing the selector
module pss_contact_model (
	// Clock that times contact changes
	input wire logic mclk,
	// Contact levels toward the selector
	output logic [6:0] pins,
	output logic fwd,
	output logic rev,
	output logic rt
);
	// All contacts open at power up
	initial
	begin
		pins = 7'h00;
		fwd = 1'b0;
		rev = 1'b0;
		rt = 1'b0;
	end
	// Contacts change just after a falling edge
	task automatic drive(input logic [6:0] p, input logic f,
		input logic r, input logic s);
		@(negedge mclk);
		pins = p;
		fwd = f;
		rev = r;
		rt = s;
	endtask
endmodule // pss_contact_model

//--- dv/pss_speed_select_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the preset speed selector
module pss_speed_select_tb;
	// Clock, reset and counters
	logic mclk = 1'b0;
	logic reset = 1'b1;
	int n_fail = 0;
	int compares = 0;
	// Contacts from the outside model
	logic [6:0] pins;
	logic fwd;
	logic rev;
	logic rt;
	// Mapping: pin0 low, 1 mid, 2 high, 3 extra, 4 inching
	logic [27:0] fmap = 28'hFF58210;
	// Mode parameters
	logic [3:0] mode = 4'h3;
	logic [1:0] remote = 2'h0;
	logic unit = 1'b0;
	// Write ports
	logic p_wr = 1'b0;
	logic [3:0] p_idx = 4'h0;
	logic [15:0] p_val = 16'h0000;
	logic [2:0] w_en = 3'h0;
	logic [15:0] w_val = 16'h0000;
	// Analog commands
	logic a2_v = 1'b0;
	logic [15:0] a2 = 16'h0ABC;
	logic [15:0] a1 = 16'h1234;
	// Results
	logic [15:0] freq;
	pss_pkg::pss_src_e src;
	logic run;
	logic [15:0] ramp;
	logic fine;
	logic [15:0] rref;
	logic sec;
	logic rem;
	// Free running clock, 20 ns period
	always #10 mclk = ~mclk;
	// Outside party
	pss_contact_model model_u (.mclk(mclk), .pins(pins), .fwd(fwd),
		.rev(rev), .rt(rt));
	// Block under test
	pss_speed_select dut_u (.mclk(mclk), .reset(reset),
		.clk_en(1'b1), .input_pins(pins), .forward_run_command(fwd),
		.reverse_run_command(rev), .second_function_select(rt),
		.input_pin_function_params(fmap), .operation_mode_param(mode),
		.remote_function_select_param(remote),
		.ramp_time_unit_param(unit), .param_write_select(2'h0),
		.preset_wr_en(p_wr), .preset_wr_index(p_idx),
		.preset_wr_value(p_val), .inching_freq_wr_en(w_en[0]),
		.inching_ramp_wr_en(w_en[1]), .ramp_ref_wr_en(w_en[2]),
		.param_wr_value(w_val), .analog2_valid(a2_v),
		.analog2_freq(a2), .analog1_freq(a1), .freq_command(freq),
		.command_source(src), .run_enable(run), .ramp_time(ramp),
		.ramp_time_fine(fine), .ramp_reference_frequency(rref),
		.use_second_ramp(sec), .remote_enable(rem));
	// Compare one value
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Let pins pass the synchroniser and output stage
	task automatic settle();
		repeat (4) @(posedge mclk);
		#1;
	endtask
	// Set contacts and wait for the result
	task automatic setp(input logic [6:0] p, input logic f,
		input logic r, input logic s);
		model_u.drive(p, f, r, s);
		settle();
	endtask
	// One preset table write
	task automatic wr_pre(input logic [3:0] i, input logic [15:0] v);
		@(negedge mclk);
		p_wr = 1'b1;
		p_idx = i;
		p_val = v;
		@(negedge mclk);
		p_wr = 1'b0;
		settle();
	endtask
	// One inching or ramp parameter write
	task automatic wr_par(input logic [2:0] e, input logic [15:0] v);
		@(negedge mclk);
		w_en = e;
		w_val = v;
		@(negedge mclk);
		w_en = 3'h0;
		settle();
	endtask
	// Reset values and idle analog pass-through
	task automatic t_reset();
		settle();
		chk(ramp, pss_pkg::INCH_RAMP_RESET);
		chk(rref, pss_pkg::RAMP_REF_RESET);
		chk(freq, a1);
		chk(16'(src), 16'(pss_pkg::PSS_SRC_ANALOG));
		chk(16'(run), 16'h0000);
		chk(16'(fine), 16'h0000);
		$display("t_reset done");
	endtask
	// Single inputs, overlaps, extra bit alone, unused speeds
	task automatic t_three();
		setp(7'h01, 1'b0, 1'b0, 1'b0);
		chk(freq, pss_pkg::LOW_RESET);
		chk(16'(src), 16'(pss_pkg::PSS_SRC_PRESET));
		setp(7'h02, 1'b0, 1'b0, 1'b0);
		chk(freq, pss_pkg::MID_RESET);
		setp(7'h04, 1'b0, 1'b0, 1'b0);
		chk(freq, pss_pkg::HIGH_RESET);
		setp(7'h06, 1'b0, 1'b0, 1'b0);
		chk(freq, pss_pkg::MID_RESET);
		setp(7'h07, 1'b0, 1'b0, 1'b0);
		chk(freq, pss_pkg::LOW_RESET);
		setp(7'h08, 1'b0, 1'b0, 1'b0);
		chk(freq, pss_pkg::ZERO_FREQ);
		setp(7'h0B, 1'b0, 1'b0, 1'b0);
		chk(freq, a1);
		setp(7'h04, 1'b0, 1'b0, 1'b1);
		chk(16'(sec), 16'h0001);
		$display("t_three done");
	endtask
	// Operation modes and remote function gate the presets
	task automatic t_mode();
		setp(7'h04, 1'b0, 1'b0, 1'b0);
		for (int m = 0; m < 3; m++)
		begin
			@(negedge mclk);
			mode = 4'(m);
			settle();
			chk(freq, a1);
		end
		@(negedge mclk);
		mode = 4'h4;
		settle();
		chk(freq, pss_pkg::HIGH_RESET);
		@(negedge mclk);
		mode = 4'h3;
		remote = 2'h1;
		settle();
		chk(freq, a1);
		chk(16'(rem), 16'h0001);
		$display("t_mode done");
	endtask
	// Priority, inching run control and inching parameters
	task automatic t_prio();
		@(negedge mclk);
		a2_v = 1'b1;
		setp(7'h00, 1'b0, 1'b0, 1'b0);
		chk(freq, a2);
		setp(7'h14, 1'b0, 1'b0, 1'b1);
		chk(freq, pss_pkg::INCH_FREQ_RESET);
		chk(16'(src), 16'(pss_pkg::PSS_SRC_INCH));
		chk(16'(run), 16'h0000);
		chk(16'(sec), 16'h0000);
		chk(16'(rem), 16'h0000);
		@(negedge mclk);
		remote = 2'h0;
		setp(7'h14, 1'b1, 1'b0, 1'b0);
		chk(16'(run), 16'h0001);
		setp(7'h14, 1'b0, 1'b1, 1'b0);
		chk(16'(run), 16'h0001);
		@(negedge mclk);
		mode = 4'h1;
		wr_par(3'h1, 16'h03E8);
		chk(freq, 16'h03E8);
		wr_par(3'h2, 16'h0007);
		chk(ramp, 16'h0007);
		wr_par(3'h2, 16'h8CA1);
		chk(ramp, 16'h0007);
		wr_par(3'h4, 16'h1388);
		chk(rref, 16'h1388);
		@(negedge mclk);
		unit = 1'b1;
		settle();
		chk(16'(fine), 16'h0001);
		setp(7'h10, 1'b0, 1'b0, 1'b0);
		chk(16'(run), 16'h0000);
		@(negedge mclk);
		mode = 4'h3;
		a2_v = 1'b0;
		$display("t_prio done");
	endtask
	// Speeds 4 to 15, range limit and writes while running
	task automatic t_multi();
		logic [3:0] cmb[12];
		cmb = '{4'h6, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB,
			4'hC, 4'hD, 4'hE, 4'hF};
		for (int k = 4; k < 16; k++)
			wr_pre(4'(k), 16'h0064 * 16'(k));
		for (int i = 0; i < 12; i++)
		begin
			setp({3'h0, cmb[i]}, 1'b1, 1'b0, 1'b0);
			chk(freq, 16'h0064 * 16'(i + 4));
		end
		setp(7'h04, 1'b1, 1'b0, 1'b0);
		wr_pre(4'h1, 16'h9C41);
		chk(freq, pss_pkg::HIGH_RESET);
		wr_pre(4'h1, pss_pkg::FREQ_MAX);
		chk(freq, pss_pkg::FREQ_MAX);
		$display("t_multi done");
	endtask
	// Moving functions to other pins
	task automatic t_remap();
		@(negedge mclk);
		fmap = 28'h58FF012;
		setp(7'h20, 1'b0, 1'b0, 1'b0);
		chk(freq, 16'h0320);
		setp(7'h40, 1'b0, 1'b0, 1'b0);
		chk(16'(src), 16'(pss_pkg::PSS_SRC_INCH));
		setp(7'h01, 1'b0, 1'b0, 1'b0);
		chk(freq, pss_pkg::FREQ_MAX);
		$display("t_remap done");
	endtask
	// Counts, verdict and end of run
	task automatic end_of_test();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence after six cycles of reset
	initial
	begin
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		t_reset();
		t_three();
		t_mode();
		t_prio();
		t_multi();
		t_remap();
		end_of_test();
	end
	// Cuts a hung run short
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		$display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
		end_of_test();
	end
endmodule // pss_speed_select_tb
